// >>> hdl/emu_evt_pkg.sv
// Purpose: Shared constants and carriers of the emulator event control block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Byte offsets below are the APB byte addresses
package emu_evt_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam logic [11:0] OFS_MASK    = 12'h008;
	localparam logic [11:0] OFS_GROUP   = 12'h00c;
	localparam logic [11:0] OFS_SPADDR  = 12'h010;
	localparam logic [11:0] OFS_IOPTR   = 12'h014;
	localparam logic [11:0] OFS_IOCTRL  = 12'h018;
	localparam logic [11:0] OFS_IOADDR  = 12'h01c;
	// Banks of eight words, selected by paddr[7:5], entry by paddr[4:2]
	localparam logic [2:0]  BANK_GD_VAL = 3'h1;
	localparam logic [2:0]  BANK_GD_DC  = 3'h2;
	localparam logic [2:0]  BANK_GR_LO  = 3'h3;
	localparam logic [2:0]  BANK_GR_HI  = 3'h4;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int         CTRL_EXQ    = 0;
	localparam int         CTRL_PIE    = 1;
	localparam int         CTRL_HIGN   = 2;
	localparam int         IOCTRL_ACT  = 0;
	localparam int         EVT_FSI     = 0;
	localparam int         EVT_HALT    = 1;
	localparam int         EVT_GROUP   = 2;
	localparam int         EVT_W       = 3;
	localparam logic       EXQ_RST     = 1'b1;
	localparam logic       PIE_RST     = 1'b0;
	localparam logic       HIGN_RST    = 1'b0;
	localparam logic [1:0] GROUP_FIRST = 2'h0;
	localparam logic [31:0] WORD_RST   = 32'h0000_0000;
	localparam int         NUM_IRQ     = 4;
	localparam int         IRQ_FOURTH  = 3;
	localparam int         LATENCY_MAX = 100;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic       emu_enter;
		logic       run_mode;
		logic       paused;
		logic       emu_reset_req;
		logic       host_busy;
		logic       evt_hit;
		logic       evt_is_group;
		logic [1:0] evt_group;
		logic       evt_is_fsi;
		logic       bus_addr_hit;
		logic       exec_addr_hit;
		logic       halt_exec;
		logic [3:0] irq_req;
		logic       irq_return;
		logic       bus_cycle;
	} tgt_in_t;

	typedef struct packed {
		logic        forced_special_interrupt;
		logic [31:0] fsi_vector;
		logic [3:0]  irq_grant;
		logic        trace_we;
		logic [1:0]  active_group;
		logic        io_mode;
		logic [31:0] io_addr;
	} tgt_out_t;

endpackage

// >>> hdl/emulator_event_control.sv
// Purpose: Event sequencer, trigger qualification, pause interrupts, registers
// Assumes: All inputs synchronous to pclk; APB master keeps the protocol
// Notes:   Every register access takes one extra wait cycle (pready from a flop)
//
// Operation
// - Qualified mode: trigger only on executed instruction
// - Unqualified mode: trigger on raw bus address
// - Prefetch-only addresses never trigger when qualified
// - Group-change action makes group 1-4 active
// - Every emulation entry restarts at group 1
// - Pause interrupts serviced only when switch on
// - Pause interrupt latency stays under 100 cycles
// - Pause-time interrupt cycles kept out of trace
// - Emulator reset request turns pause interrupts off
// - Fourth interrupt input blocked during pause
// - Run-mode halt flags error unless ignored
// - I/O pointer resets to zero, fully writable
// - I/O mode starts at and updates pointer
// - Eight data registers with don't-care masks
// - Eight address registers holding single or range
// - Trigger vectors to 32-bit special address
`timescale 1ns/100ps
module emulator_event_control #(
	parameter bit BLOCK_FOURTH_IRQ = 1'b1
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire emu_evt_pkg::apb_req_t apb,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire emu_evt_pkg::tgt_in_t  tgt,
	output emu_evt_pkg::tgt_out_t      tout,
	output logic                      irq
);
	import emu_evt_pkg::*;

	typedef struct packed {
		logic              exq;
		logic              pie;
		logic              hign;
		logic [EVT_W-1:0]  status;
		logic [EVT_W-1:0]  mask;
		logic [1:0]        group;
		logic [31:0]       spaddr;
		logic [31:0]       ioptr;
		logic              io_act;
		logic [7:0][31:0]  gd_val;
		logic [7:0][31:0]  gd_dc;
		logic [7:0][31:0]  gr_lo;
		logic [7:0][31:0]  gr_hi;
		logic              isr_act;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic              irq;
		tgt_out_t          tout;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic       acc;
	logic       done;
	logic       wr_go;
	logic       rd_go;
	logic [2:0] bank;
	logic [2:0] idx;
	logic       bank_hit;
	logic       fsi_hit;
	logic [EVT_W-1:0] evt;
	logic [3:0] irq_allow;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	assign acc      = apb.psel && apb.penable;
	assign done     = acc && st_r.pready;
	assign wr_go    = done && apb.pwrite && !st_r.pslverr;
	assign rd_go    = done && !apb.pwrite && !st_r.pslverr;
	assign bank     = apb.paddr[7:5];
	assign idx      = apb.paddr[4:2];
	assign bank_hit = (apb.paddr[11:8] == 4'h0) && (apb.paddr[1:0] == 2'h0)
		&& (bank >= BANK_GD_VAL) && (bank <= BANK_GR_HI);

	// Trigger source selection: executed instruction or raw bus address
	assign fsi_hit = tgt.evt_hit && tgt.evt_is_fsi && tgt.run_mode
		&& (st_r.exq ? tgt.exec_addr_hit : tgt.bus_addr_hit);

	// Pause interrupt gate; fourth input stays blocked while paused
	always_comb begin
		irq_allow = 4'h0;
		if (tgt.run_mode && !tgt.paused) begin
			irq_allow = tgt.irq_req;
		end else if (tgt.paused && st_r.pie && !tgt.host_busy) begin
			irq_allow = tgt.irq_req;
			if (BLOCK_FOURTH_IRQ) begin
				irq_allow[IRQ_FOURTH] = 1'b0;
			end
		end
	end

	// Events that set sticky status bits
	always_comb begin
		evt            = '0;
		evt[EVT_FSI]   = fsi_hit;
		evt[EVT_HALT]  = tgt.halt_exec && tgt.run_mode && !st_r.hign;
		evt[EVT_GROUP] = tgt.evt_hit && tgt.evt_is_group && tgt.run_mode;
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// APB: first access cycle computes the answer, second one completes
		st_nxt.pready = acc && !st_r.pready;
		if (acc && !st_r.pready) begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = WORD_RST;
			if (bank_hit) begin
				unique case (bank)
					BANK_GD_VAL: st_nxt.prdata = st_r.gd_val[idx];
					BANK_GD_DC:  st_nxt.prdata = st_r.gd_dc[idx];
					BANK_GR_LO:  st_nxt.prdata = st_r.gr_lo[idx];
					default:     st_nxt.prdata = st_r.gr_hi[idx];
				endcase
			end else begin
				unique case (apb.paddr)
					OFS_CTRL:   st_nxt.prdata = {29'h0, st_r.hign, st_r.pie, st_r.exq};
					OFS_STATUS: st_nxt.prdata = {29'h0, st_r.status};
					OFS_MASK:   st_nxt.prdata = {29'h0, st_r.mask};
					OFS_GROUP:  st_nxt.prdata = {30'h0, st_r.group};
					OFS_SPADDR: st_nxt.prdata = st_r.spaddr;
					OFS_IOPTR:  st_nxt.prdata = st_r.ioptr;
					OFS_IOCTRL: st_nxt.prdata = {31'h0, st_r.io_act};
					OFS_IOADDR: st_nxt.prdata = st_r.ioptr;
					default:    st_nxt.pslverr = 1'b1;
				endcase
			end
		end else if (!acc) begin
			st_nxt.pslverr = 1'b0;
		end

		// Software writes at the completing edge
		if (wr_go) begin
			if (bank_hit) begin
				unique case (bank)
					BANK_GD_VAL: st_nxt.gd_val[idx] = apb.pwdata;
					BANK_GD_DC:  st_nxt.gd_dc[idx]  = apb.pwdata;
					BANK_GR_LO:  st_nxt.gr_lo[idx]  = apb.pwdata;
					default:     st_nxt.gr_hi[idx]  = apb.pwdata;
				endcase
			end else begin
				unique case (apb.paddr)
					OFS_CTRL: begin
						st_nxt.exq  = apb.pwdata[CTRL_EXQ];
						st_nxt.pie  = apb.pwdata[CTRL_PIE];
						st_nxt.hign = apb.pwdata[CTRL_HIGN];
					end
					OFS_MASK:   st_nxt.mask   = apb.pwdata[EVT_W-1:0];
					OFS_SPADDR: st_nxt.spaddr = apb.pwdata;
					OFS_IOPTR:  st_nxt.ioptr  = apb.pwdata;
					OFS_IOCTRL: st_nxt.io_act = apb.pwdata[IOCTRL_ACT];
					OFS_IOADDR: begin
						if (st_r.io_act) begin
							st_nxt.ioptr = apb.pwdata;
						end
					end
					default: st_nxt.exq = st_r.exq;
				endcase
			end
		end

		// Reset request wins over a software write of the switch
		if (tgt.emu_reset_req) begin
			st_nxt.pie = 1'b0;
		end

		// Sticky status: read clears, a new event in the same cycle wins
		if (rd_go && (apb.paddr == OFS_STATUS)) begin
			st_nxt.status = '0;
		end
		st_nxt.status = st_nxt.status | evt;

		// Active group register
		if (tgt.emu_enter) begin
			st_nxt.group = GROUP_FIRST;
		end else if (evt[EVT_GROUP]) begin
			st_nxt.group = tgt.evt_group;
		end

		// Interrupt routine served during pause is tracked until its return
		if (tgt.paused && |irq_allow) begin
			st_nxt.isr_act = 1'b1;
		end else if (tgt.irq_return || !tgt.paused) begin
			st_nxt.isr_act = 1'b0;
		end

		// Registered outputs
		st_nxt.irq                           = |(st_nxt.status & st_nxt.mask);
		st_nxt.tout.forced_special_interrupt = fsi_hit;
		st_nxt.tout.fsi_vector               = st_r.spaddr;
		st_nxt.tout.irq_grant                = irq_allow;
		st_nxt.tout.trace_we                 = tgt.bus_cycle
			&& !(tgt.paused && (st_r.isr_act || |irq_allow));
		st_nxt.tout.active_group             = st_nxt.group;
		st_nxt.tout.io_mode                  = st_nxt.io_act;
		st_nxt.tout.io_addr                  = st_nxt.ioptr;
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= '0;
			st_r.exq  <= EXQ_RST;
			st_r.pie  <= PIE_RST;
			st_r.hign <= HIGN_RST;
			st_r.ioptr <= WORD_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata  = st_r.prdata;
	assign pready  = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign tout    = st_r.tout;
	assign irq     = st_r.irq;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_exec_only;
		st_r.exq && tgt.evt_hit && tgt.evt_is_fsi && tgt.run_mode && tgt.exec_addr_hit
			|=> tout.forced_special_interrupt;
	endproperty
	a_exec_only: assert property (p_exec_only) else $error("qualified trigger missed");

	property p_bus_addr;
		!st_r.exq && tgt.evt_hit && tgt.evt_is_fsi && tgt.run_mode && tgt.bus_addr_hit
			|=> tout.forced_special_interrupt ##0 (tout.fsi_vector == $past(st_r.spaddr));
	endproperty
	a_bus_addr: assert property (p_bus_addr) else $error("bus address trigger missed");

	property p_no_prefetch;
		st_r.exq && !tgt.exec_addr_hit |=> !tout.forced_special_interrupt;
	endproperty
	a_no_prefetch: assert property (p_no_prefetch) else $error("prefetch raised trigger");

	property p_group_change;
		tgt.evt_hit && tgt.evt_is_group && tgt.run_mode && !tgt.emu_enter
			|=> tout.active_group == $past(tgt.evt_group);
	endproperty
	a_group_change: assert property (p_group_change) else $error("group not switched");

	property p_entry_group;
		tgt.emu_enter |=> (st_r.group == GROUP_FIRST) ##0 (tout.active_group == GROUP_FIRST);
	endproperty
	a_entry_group: assert property (p_entry_group) else $error("entry not at group 1");

	property p_group_stable;
		!tgt.emu_enter && !(tgt.evt_hit && tgt.evt_is_group && tgt.run_mode)
			|=> $stable(st_r.group);
	endproperty
	a_group_stable: assert property (p_group_stable) else $error("group moved unasked");

	property p_pause_gate;
		tgt.paused && !st_r.pie |=> tout.irq_grant == 4'h0;
	endproperty
	a_pause_gate: assert property (p_pause_gate) else $error("pause interrupt not ignored");

	property p_pause_latency;
		tgt.paused && st_r.pie && !tgt.host_busy && tgt.irq_req[0]
			|-> ##[1:2] tout.irq_grant[0];
	endproperty
	a_pause_latency: assert property (p_pause_latency) else $error("pause latency too long");

	property p_reset_req;
		tgt.emu_reset_req |=> !st_r.pie
			##1 (!st_r.pie || $past(wr_go && (apb.paddr == OFS_CTRL)));
	endproperty
	a_reset_req: assert property (p_reset_req) else $error("switch not forced off");

	property p_fourth_blocked;
		tgt.paused |=> !tout.irq_grant[IRQ_FOURTH];
	endproperty
	a_fourth_blocked: assert property (p_fourth_blocked) else $error("fourth input served");

	property p_no_trace;
		tgt.paused && st_r.isr_act |=> !tout.trace_we;
	endproperty
	a_no_trace: assert property (p_no_trace) else $error("pause service traced");

	property p_halt_err;
		tgt.halt_exec && tgt.run_mode && !st_r.hign |=> st_r.status[EVT_HALT];
	endproperty
	a_halt_err: assert property (p_halt_err) else $error("halt error not reported");

	property p_io_move;
		wr_go && (apb.paddr == OFS_IOADDR) && st_r.io_act
			|=> tout.io_addr == $past(apb.pwdata);
	endproperty
	a_io_move: assert property (p_io_move) else $error("pointer not updated");

endmodule

// >>> test/target_proc_model.sv
// Purpose: Behavioural target processor facing the event control block
// Assumes: Bench sets levels directly and one-cycle pulses through the pulse task here
// Notes:   A serviced routine runs three cycles, then returns normally
`timescale 1ns/100ps
module target_proc_model (
	input  wire logic                  pclk,
	output emu_evt_pkg::tgt_in_t       tgt,
	input  wire emu_evt_pkg::tgt_out_t tout
);
	import emu_evt_pkg::*;
	tgt_in_t    lvl = '0;
	tgt_in_t    pls = '0;
	logic [3:0] req = 4'h0;
	logic       ret = 1'b0;
	logic [2:0] isr_cnt = 3'h0;
	logic [7:0] pause_area [16];
	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Levels, pulses and interrupt lines merged onto the pins
	always_comb begin
		tgt = tgt_in_t'(lvl | pls);
		tgt.irq_req = req;
		tgt.irq_return = ret;
	end
	// One-cycle pulse launched just after a rising edge
	task automatic pulse(input tgt_in_t v);
		@(posedge pclk);
		pls <= v;
		@(posedge pclk);
		pls <= '0;
	endtask
	// Granted routine during pause: short body, normal return, no halt
	always @(posedge pclk) begin
		ret <= 1'b0;
		if (isr_cnt != 3'h0) begin
			isr_cnt <= isr_cnt - 3'h1;
			if (isr_cnt == 3'h1) begin
				ret <= 1'b1;
				req <= 4'h0;
			end
		end else if (tout.irq_grant != 4'h0 && req != 4'h0 && lvl.paused) begin
			isr_cnt <= 3'h3;
		end
	end
endmodule

// >>> test/emulator_event_control_tb.sv
// Purpose: Self-checking bench of the emulator event control block
// Assumes: APB reads answer through pready; target pins via the model
// Notes:   Outputs are read at a rising edge before that edge lands
`timescale 1ns/100ps
module emulator_event_control_tb;
	import emu_evt_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	apb_req_t    apb = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	tgt_in_t     tgt;
	tgt_out_t    tout;
	logic [31:0] rd;
	logic        er;
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	emulator_event_control u_dut (.pclk(pclk), .presetn(presetn), .apb(apb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tgt(tgt), .tout(tout),
		.irq(irq));
	target_proc_model u_tgt (.pclk(pclk), .tgt(tgt), .tout(tout));
	initial forever #2 pclk = ~pclk;
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			summarize();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb.penable <= 1'b1;
		// Wait for pready high; with no timeout here, a missing answer is ended only by the bench hang guard
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		apb <= '0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb_xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
		apb_xfer(1'b0, a, 32'h0000_0000);
		check(n, e, rd);
	endtask
	// Pulse, then stop at the edge where the registered answer shows
	task automatic fire(input tgt_in_t v);
		u_tgt.pulse(v);
		@(posedge pclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk(OFS_CTRL, 32'h0000_0001, "ctrl");
		rdchk(OFS_IOPTR, WORD_RST, "io pointer");
		rdchk(OFS_GROUP, 32'h0000_0000, "group");
		rdchk({4'h0, BANK_GD_VAL, 5'h00}, WORD_RST, "data reg");
		apb_xfer(1'b0, 12'h0a0, 32'h0000_0000);
		check("slverr", 32'h0000_0001, 32'(er));
		$display("test reset done");
	endtask
	task automatic t_fsi();
		tgt_in_t v = '0;
		wr(OFS_SPADDR, 32'h8f36_1000);
		wr(OFS_MASK, 32'h0000_0001);
		u_tgt.lvl.run_mode <= 1'b1;
		v.evt_hit = 1'b1;
		v.evt_is_fsi = 1'b1;
		v.bus_addr_hit = 1'b1;
		fire(v);
		check("fsi prefetch", 32'h0, 32'(tout.forced_special_interrupt));
		v.exec_addr_hit = 1'b1;
		fire(v);
		check("fsi exec", 32'h1, 32'(tout.forced_special_interrupt));
		check("fsi vector", 32'h8f36_1000, tout.fsi_vector);
		@(posedge pclk);
		check("irq set", 32'h1, 32'(irq));
		rdchk(OFS_STATUS, 32'h0000_0001, "status");
		rdchk(OFS_STATUS, 32'h0000_0000, "status clr");
		check("irq clr", 32'h0, 32'(irq));
		wr(OFS_MASK, 32'h0000_0000);
		fire(v);
		@(posedge pclk);
		check("irq masked", 32'h0, 32'(irq));
		wr(OFS_CTRL, 32'h0000_0000);
		v.exec_addr_hit = 1'b0;
		fire(v);
		check("fsi bus", 32'h1, 32'(tout.forced_special_interrupt));
		$display("test fsi done");
	endtask
	task automatic t_grp();
		tgt_in_t v = '0;
		v.evt_hit = 1'b1;
		v.evt_is_group = 1'b1;
		for (int g = 3; g >= 0; g--) begin
			v.evt_group = 2'(g);
			fire(v);
			check("group", 32'(g), 32'(tout.active_group));
		end
		v.evt_is_group = 1'b0;
		v.evt_group = 2'h2;
		fire(v);
		check("group hold", 32'h0, 32'(tout.active_group));
		v.evt_is_group = 1'b1;
		fire(v);
		check("group 3", 32'h2, 32'(tout.active_group));
		v.emu_enter = 1'b1;
		fire(v);
		check("group entry", 32'h0, 32'(tout.active_group));
		rdchk(OFS_GROUP, 32'h0000_0000, "group reg");
		$display("test group done");
	endtask
	task automatic t_pause();
		tgt_in_t v = '0;
		v.bus_cycle = 1'b1;
		u_tgt.req <= 4'h8;
		fire(v);
		check("trace run", 32'h1, 32'(tout.trace_we));
		check("grant run", 32'h8, 32'(tout.irq_grant));
		u_tgt.lvl.run_mode <= 1'b0;
		u_tgt.lvl.paused <= 1'b1;
		u_tgt.req <= 4'h1;
		repeat (3) @(posedge pclk);
		check("grant off", 32'h0, 32'(tout.irq_grant));
		wr(OFS_CTRL, 32'h0000_0003);
		u_tgt.req <= 4'h9;
		fire(v);
		check("grant pause", 32'h1, 32'(tout.irq_grant));
		check("trace pause", 32'h0, 32'(tout.trace_we));
		repeat (6) @(posedge pclk);
		check("grant done", 32'h0, 32'(tout.irq_grant));
		// A host command in progress defers pause interrupts
		u_tgt.lvl.host_busy <= 1'b1;
		u_tgt.req <= 4'h1;
		repeat (3) @(posedge pclk);
		check("grant busy", 32'h0, 32'(tout.irq_grant));
		u_tgt.lvl.host_busy <= 1'b0;
		u_tgt.req <= 4'h0;
		v = '0;
		v.emu_reset_req = 1'b1;
		u_tgt.pulse(v);
		rdchk(OFS_CTRL, 32'h0000_0001, "pie reset");
		u_tgt.req <= 4'h1;
		repeat (3) @(posedge pclk);
		check("grant reset", 32'h0, 32'(tout.irq_grant));
		u_tgt.req <= 4'h0;
		u_tgt.lvl.paused <= 1'b0;
		u_tgt.lvl.run_mode <= 1'b1;
		$display("test pause done");
	endtask
	task automatic t_halt();
		tgt_in_t v = '0;
		v.halt_exec = 1'b1;
		apb_xfer(1'b0, OFS_STATUS, 32'h0000_0000);
		fire(v);
		rdchk(OFS_STATUS, 32'h0000_0002, "halt err");
		wr(OFS_CTRL, 32'h0000_0005);
		fire(v);
		rdchk(OFS_STATUS, 32'h0000_0000, "halt ign");
		$display("test halt done");
	endtask
	task automatic t_io();
		wr(OFS_IOPTR, 32'h0000_1100);
		rdchk(OFS_IOPTR, 32'h0000_1100, "io pointer");
		wr(OFS_IOCTRL, 32'h0000_0001);
		@(posedge pclk);
		check("io mode", 32'h1, 32'(tout.io_mode));
		check("io entry", 32'h0000_1100, tout.io_addr);
		wr(OFS_IOADDR, 32'hffff_0001);
		wr(OFS_IOCTRL, 32'h0000_0000);
		rdchk(OFS_IOPTR, 32'hffff_0001, "io last");
		wr(OFS_IOADDR, 32'h0000_0005);
		rdchk(OFS_IOADDR, 32'hffff_0001, "io no move");
		$display("test io done");
	endtask
	task automatic t_regs();
		for (int b = 1; b <= 4; b++)
			for (int i = 0; i < 8; i++)
				wr({4'h0, 3'(b), 3'(i), 2'b00}, 32'h5a5a_0000 + 32'(b * 16 + i));
		for (int b = 1; b <= 4; b++)
			for (int i = 0; i < 8; i++)
				rdchk({4'h0, 3'(b), 3'(i), 2'b00}, 32'h5a5a_0000 + 32'(b * 16 + i),
					"gen reg");
		$display("test regs done");
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fsi();
		t_grp();
		t_pause();
		t_halt();
		t_io();
		t_regs();
		summarize();
	end
endmodule
